// ### design/hp_host_port.sv
// Purpose: handshake and strobe selection of a 16-bit host port
// Assumes: host pins are asynchronous to clk; avalon master on clk
// Notes: host reads drain the outbound buffer, host writes fill the inbound one
//
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "hp_params.svh"
module hp_host_port
(
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output      logic [31:0] avs_readdata,
   output      logic        avs_waitrequest,
   input  wire logic [1:0]  host_chip_selects,
   input  wire logic [3:0]  host_address_lines,
   input  wire logic        host_direction,
   input  wire logic        host_read_strobe,
   input  wire logic        host_write_strobe,
   input  wire logic        host_shared_strobe,
   input  wire logic        host_dma_acknowledge,
   input  wire logic [15:0] host_data_in,
   output      logic [15:0] host_data_out,
   output      logic        host_data_oe,
   output      logic        host_request_combined,
   output      logic        host_receive_request,
   output      logic        host_transmit_request
);

   // true when a pin sits at its programmed active level
   function automatic logic pin_active(input logic pin, input logic pol);
      return pol ? pin : ~pin;
   endfunction: pin_active

   // byte lane merge for software writes
   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++)
         if (be[i])
            res[i*8 +: 8] = new_v[i*8 +: 8];
      return res;
   endfunction: be_merge

   logic [`HP_CTRL_W-1:0]   ctrl_reg;
   logic [31:0]             tx_lo_reg;
   logic [31:0]             rdata_reg;
   logic                    ack_reg;
   logic [`HP_SYNC_W-1:0]   sync1_reg;
   logic [`HP_SYNC_W-1:0]   sync2_reg;
   hp_pkg::hp_state_t       state_reg;
   logic [3:0]              addr_reg;
   logic [`HP_GAP_W-1:0]    gap_reg;
   logic [1:0]              dma_ptr_reg;
   logic [15:0]             wdata_reg;
   logic [15:0]             stage_reg [4];
   logic                    push_pend_reg;
   logic [15:0]             hd_out_reg;
   logic                    hd_oe_reg;
   logic                    req_comb_reg;
   logic                    req_rx_reg;
   logic                    req_tx_reg;

   logic        pol_cs, pol_stb, pol_ack, pol_req;
   logic        dual_mode, double_req, big_end, ack_src, dma_en, wide_mode;
   logic [1:0]  s_cs;
   logic        s_rd, s_wr, s_ds, s_ack, s_dir;
   logic [3:0]  s_addr;
   logic [15:0] s_data;
   logic        cs_sel, rd_stb, wr_stb, ack_act, dma_rd, dma_wr;
   logic        acc_rd, acc_wr, acc_end, last_hit, rd_done, wr_done, ob_pop;
   logic [3:0]  eff_addr, rd_addr;
   logic [1:0]  widx, rd_widx;
   logic        is_data, rd_is_data;
   logic [15:0] rd_value;
   logic        rx_lvl, tx_lvl, blk, recv_act, xmit_act;
   logic        av_req, av_blocked, av_accept;
   logic        ob_in_valid, ob_in_ready, ob_out_valid;
   logic [63:0] ob_in_data, ob_out_data;
   logic        ib_in_ready, ib_out_valid, ib_out_ready;
   logic [63:0] ib_in_data, ib_out_data;

   // control fields
   assign pol_cs     = ctrl_reg[`HP_CB_POL_CS];
   assign pol_stb    = ctrl_reg[`HP_CB_POL_STB];
   assign pol_ack    = ctrl_reg[`HP_CB_POL_ACK];
   assign pol_req    = ctrl_reg[`HP_CB_POL_REQ];
   assign dual_mode  = ctrl_reg[`HP_CB_DUAL];
   assign double_req = ctrl_reg[`HP_CB_DOUBLE];
   assign big_end    = ctrl_reg[`HP_CB_BIG];
   assign ack_src    = ctrl_reg[`HP_CB_ACK_SRC];
   assign dma_en     = ctrl_reg[`HP_CB_DMA];
   assign wide_mode  = ctrl_reg[`HP_CB_WIDE];

   // two-stage synchroniser; reset to ones so nothing looks active at reset
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sync1_reg <= '1;
         sync2_reg <= '1;
      end
      else
      begin
         sync1_reg <= {host_chip_selects, host_read_strobe, host_write_strobe,
                       host_shared_strobe, host_dma_acknowledge, host_direction,
                       host_address_lines, host_data_in};
         sync2_reg <= sync1_reg;
      end
   end

   // unpack the synchronised bundle
   assign s_cs   = sync2_reg[26:25];
   assign s_rd   = sync2_reg[24];
   assign s_wr   = sync2_reg[23];
   assign s_ds   = sync2_reg[22];
   assign s_ack  = sync2_reg[21];
   assign s_dir  = sync2_reg[20];
   assign s_addr = sync2_reg[19:16];
   assign s_data = sync2_reg[15:0];

   // strobe selection; host_direction high means read in shared mode
   assign cs_sel  = pin_active(s_cs[0], pol_cs) | pin_active(s_cs[1], pol_cs);
   assign rd_stb  = dual_mode ? pin_active(s_rd, pol_stb)
                              : pin_active(s_ds, pol_stb) & s_dir;
   assign wr_stb  = dual_mode ? pin_active(s_wr, pol_stb)
                              : pin_active(s_ds, pol_stb) & ~s_dir;
   assign ack_act = pin_active(s_ack, pol_ack);

   // dma qualifier comes from the acknowledge or from the strobes
   assign dma_rd = ack_src ? rd_stb : (ack_act & s_dir);
   assign dma_wr = ack_src ? wr_stb : (ack_act & ~s_dir);
   assign acc_rd = dma_en ? dma_rd : (cs_sel & rd_stb);
   assign acc_wr = dma_en ? dma_wr : (cs_sel & wr_stb);

   // dma walks the data page itself, the host address lines are ignored
   assign eff_addr = !dma_en   ? s_addr :
                     wide_mode ? {`HP_HA_DATA_PAGE, dma_ptr_reg} : `HP_HA_LAST;

   // data page decode; narrow mode keeps only the last register
   assign is_data  = wide_mode ? (addr_reg[3:2] == `HP_HA_DATA_PAGE)
                               : (addr_reg == `HP_HA_LAST);
   assign last_hit = (addr_reg == `HP_HA_LAST);
   assign widx     = !wide_mode ? 2'h0 :
                     big_end    ? addr_reg[1:0] : 2'h3 - addr_reg[1:0];

   assign rd_done = (state_reg == hp_pkg::st_read) & ~acc_rd;
   assign wr_done = (state_reg == hp_pkg::st_write) & ~acc_wr;
   assign acc_end = rd_done | wr_done;
   assign ob_pop  = rd_done & last_hit;

   // access sequencer
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_reg <= hp_pkg::st_idle;
         addr_reg  <= 4'h0;
      end
      else
      begin
         case (state_reg)
            hp_pkg::st_idle:
            begin
               if (acc_rd)
               begin
                  state_reg <= hp_pkg::st_read;
                  addr_reg  <= eff_addr;
               end
               else if (acc_wr)
               begin
                  state_reg <= hp_pkg::st_write;
                  addr_reg  <= eff_addr;
               end
            end
            hp_pkg::st_read, hp_pkg::st_write:
            begin
               if (acc_end)
                  state_reg <= dma_en ? hp_pkg::st_gap : hp_pkg::st_idle;
            end
            hp_pkg::st_gap:
            begin
               if (gap_reg == '0)
                  state_reg <= hp_pkg::st_idle;
            end
            default:
               state_reg <= hp_pkg::st_idle;
         endcase
      end
   end

   // holdoff count, the gap state lasts exactly the holdoff cycles
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         gap_reg <= '0;
      else if (acc_end)
         gap_reg <= `HP_GAP_W'(`HP_HOLDOFF_CYC - 1);
      else if ((state_reg == hp_pkg::st_gap) && (gap_reg != '0))
         gap_reg <= gap_reg - `HP_GAP_W'(1);
   end

   // dma word pointer restarts after the last register
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         dma_ptr_reg <= 2'h0;
      else if (!dma_en || (acc_end && last_hit))
         dma_ptr_reg <= 2'h0;
      else if (acc_end && is_data)
         dma_ptr_reg <= dma_ptr_reg + 2'h1;
   end

   // write data is caught while the strobe is still seen active,
   // because the pin hold after the strobe is far shorter than a sync delay
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         wdata_reg <= 16'h0;
      else if (acc_wr)
         wdata_reg <= s_data;
   end

   // staging words of the inbound transfer
   genvar gw;
   generate
      for (gw = 0; gw < 4; gw++)
      begin : g_stage
         always_ff @(posedge clk or negedge arst_n)
         begin
            if (!arst_n)
               stage_reg[gw] <= 16'h0;
            else if (wr_done && is_data && (widx == 2'(gw)))
               stage_reg[gw] <= wdata_reg;
         end
      end
   endgenerate

   // a finished word waits here until the inbound buffer takes it;
   // a new completion wins over the clear in the same cycle
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         push_pend_reg <= 1'h0;
      else if (wr_done && last_hit)
         push_pend_reg <= 1'h1;
      else if (ib_in_ready)
         push_pend_reg <= 1'h0;
   end

   assign ib_in_data = wide_mode ? {stage_reg[3], stage_reg[2], stage_reg[1], stage_reg[0]}
                                 : {48'h0, stage_reg[0]};

   // host read value, taken from the address seen at access start
   assign rd_addr    = (state_reg == hp_pkg::st_idle) ? eff_addr : addr_reg;
   assign rd_is_data = wide_mode ? (rd_addr[3:2] == `HP_HA_DATA_PAGE)
                                 : (rd_addr == `HP_HA_LAST);
   assign rd_widx    = !wide_mode ? 2'h0 :
                       big_end    ? rd_addr[1:0] : 2'h3 - rd_addr[1:0];

   always_comb
   begin
      rd_value = 16'h0;
      if (rd_is_data)
         rd_value = ob_out_data[rd_widx*16 +: 16];
      else if (rd_addr == `HP_HA_STATUS)
         rd_value = {14'h0, tx_lvl, rx_lvl};
   end

   // data bus drive; limited by the sync delay, not by the core
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         hd_out_reg <= 16'h0;
         hd_oe_reg  <= 1'h0;
      end
      else
      begin
         hd_out_reg <= rd_value;
         hd_oe_reg  <= acc_rd;
      end
   end

   assign host_data_out = hd_out_reg;
   assign host_data_oe  = hd_oe_reg;

   // request levels follow buffer state and the waiting word; a dma access or holdoff masks them
   assign rx_lvl   = ob_out_valid;
   assign tx_lvl   = ib_in_ready & ~push_pend_reg;
   assign blk      = dma_en & (state_reg != hp_pkg::st_idle);
   assign recv_act = rx_lvl & ~blk;
   assign xmit_act = tx_lvl & ~blk;

   // request pins, inactive level when unused by the current mode
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         req_comb_reg <= 1'h1;
         req_rx_reg   <= 1'h1;
         req_tx_reg   <= 1'h1;
      end
      else
      begin
         req_comb_reg <= pin_active(~double_req & (recv_act | xmit_act), pol_req);
         req_rx_reg   <= pin_active(double_req & recv_act, pol_req);
         req_tx_reg   <= pin_active(double_req & xmit_act, pol_req);
      end
   end

   assign host_request_combined = req_comb_reg;
   assign host_receive_request  = req_rx_reg;
   assign host_transmit_request = req_tx_reg;

   // avalon slave: one wait cycle, more for a high-half write while the outbound buffer is full
   assign av_req          = avs_read | avs_write;
   assign av_blocked      = avs_write & (avs_address == `HP_AV_TX_HI) & ~ob_in_ready;
   assign av_accept       = av_req & ack_reg & ~av_blocked;
   assign avs_waitrequest = av_req & ~(ack_reg & ~av_blocked);
   assign avs_readdata    = rdata_reg;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         ack_reg <= 1'h0;
      else
         ack_reg <= av_req & ~av_accept;
   end

   // read data captured in the wait cycle; unmapped offsets read zero
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         rdata_reg <= 32'h0;
      else if (avs_read && !ack_reg)
      begin
         case (avs_address)
            `HP_AV_CTRL:   rdata_reg <= {22'h0, ctrl_reg};
            `HP_AV_STATUS: rdata_reg <= {24'h0, state_reg, xmit_act, recv_act,
                                         ib_out_valid, ib_in_ready,
                                         ob_out_valid, ob_in_ready};
            `HP_AV_TX_LO:  rdata_reg <= tx_lo_reg;
            `HP_AV_RX_LO:  rdata_reg <= ib_out_data[31:0];
            `HP_AV_RX_HI:  rdata_reg <= ib_out_data[63:32];
            default:       rdata_reg <= 32'h0;
         endcase
      end
   end

   // software registers; polarity and modes steer the host side
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctrl_reg  <= `HP_CTRL_RESET;
         tx_lo_reg <= 32'h0;
      end
      else if (av_accept && avs_write)
      begin
         if (avs_address == `HP_AV_CTRL)
            ctrl_reg <= `HP_CTRL_W'(be_merge({22'h0, ctrl_reg}, avs_writedata,
                                             avs_byteenable));
         if (avs_address == `HP_AV_TX_LO)
            tx_lo_reg <= be_merge(tx_lo_reg, avs_writedata, avs_byteenable);
      end
   end

   // writing the high half queues a whole word for the host
   assign ob_in_valid  = av_accept & avs_write & (avs_address == `HP_AV_TX_HI);
   assign ob_in_data   = {avs_writedata, tx_lo_reg};
   assign ib_out_ready = av_accept & avs_read & (avs_address == `HP_AV_RX_HI);

   // host-bound words
   hp_buf2
   #(
      .WIDTH (`HP_XFER_W),
      .DEPTH (`HP_BUF_DEPTH)
   )
   u_outbound_fifo
   (
      .clk       (clk),
      .arst_n    (arst_n),
      .in_valid  (ob_in_valid),
      .in_ready  (ob_in_ready),
      .in_data   (ob_in_data),
      .out_valid (ob_out_valid),
      .out_ready (ob_pop),
      .out_data  (ob_out_data)
   );

   // words written by the host
   hp_buf2
   #(
      .WIDTH (`HP_XFER_W),
      .DEPTH (`HP_BUF_DEPTH)
   )
   u_inbound_fifo
   (
      .clk       (clk),
      .arst_n    (arst_n),
      .in_valid  (push_pend_reg),
      .in_ready  (ib_in_ready),
      .in_data   (ib_in_data),
      .out_valid (ib_out_valid),
      .out_ready (ib_out_ready),
      .out_data  (ib_out_data)
   );

endmodule: hp_host_port

// ### pkg/hp_params.svh
// Purpose: constants of the host port handshake block
// Assumes: clk is the core clock, one core period per cycle
// Notes: host side times are kept in tenths of a core period
// Function
// - control pin polarity is software programmable
// - read strobe follows dual or single mode
// - write strobe follows dual or single mode
// - address seven is the last data register
// - last register maps word zero or three
// - combined or split request outputs by mode
// - receive request drops when outbound empty, or while a dma access or holdoff runs
// - transmit request drops when inbound full or a finished word waits to enter it
// - request drops soon after last register read
// - request drops soon after last register write
// - dma qualifier source selectable, request holdoff
// - dma request drops after qualifier asserts
// - read data valid soon after strobe asserts
`ifndef HP_PARAMS_SVH
`define HP_PARAMS_SVH

// avalon byte offsets
`define HP_AV_CTRL        8'h00
`define HP_AV_STATUS      8'h04
`define HP_AV_TX_LO       8'h08
`define HP_AV_TX_HI       8'h0C
`define HP_AV_RX_LO       8'h10
`define HP_AV_RX_HI       8'h14

// port control register fields
`define HP_CTRL_W         10
`define HP_CTRL_RESET     10'h210
`define HP_CB_POL_CS      0
`define HP_CB_POL_STB     1
`define HP_CB_POL_ACK     2
`define HP_CB_POL_REQ     3
`define HP_CB_DUAL        4
`define HP_CB_DOUBLE      5
`define HP_CB_BIG         6
`define HP_CB_ACK_SRC     7
`define HP_CB_DMA         8
`define HP_CB_WIDE        9

// host side addresses
`define HP_HA_STATUS      4'h0
`define HP_HA_LAST        4'h7
`define HP_HA_DATA_PAGE   2'h1

// host pin bundle width and word sizes
`define HP_SYNC_W         27
`define HP_HWORD_W        16
`define HP_XFER_W         64
`define HP_BUF_DEPTH      2

// dma request holdoff, least time rounds up
`define HP_CORE_TENTHS    10
`define HP_HOLDOFF_TENTHS 50
`define HP_HOLDOFF_CYC    ((`HP_HOLDOFF_TENTHS + `HP_CORE_TENTHS - 1) / `HP_CORE_TENTHS)
`define HP_GAP_W          3

`endif

// ### pkg/hp_pkg.sv
// Purpose: types of the host port handshake block
// Assumes: nothing beyond the params header
// Notes: access sequencer states
package hp_pkg;

   typedef enum logic [1:0]
   {
      st_idle  = 2'b00,
      st_read  = 2'b01,
      st_write = 2'b10,
      st_gap   = 2'b11
   } hp_state_t;

endpackage: hp_pkg

// ### design/hp_buf2.sv
// Purpose: small valid/ready buffer for transfer words
// Assumes: DEPTH is a power of two
// Notes: out_data is a mux of flip-flops, valid with out_valid
`timescale 1ns/100ps
module hp_buf2
#(
   parameter int WIDTH = 64,
   parameter int DEPTH = 2
)
(
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [CW-1:0]    count_reg;
   logic             push;
   logic             pop;

   // honest flags straight from the occupancy count
   assign in_ready  = (count_reg != CW'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem_reg[rd_ptr_reg];

   // one storage word per entry
   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++)
      begin : g_entry
         always_ff @(posedge clk or negedge arst_n)
         begin
            if (!arst_n)
               mem_reg[gi] <= '0;
            else if (push && (wr_ptr_reg == AW'(gi)))
               mem_reg[gi] <= in_data;
         end
      end
   endgenerate

   // pointers wrap naturally since depth is a power of two
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_reg <= wr_ptr_reg + AW'(1);
         if (pop)
            rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
   end

   // occupancy
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         count_reg <= '0;
      else if (push && !pop)
         count_reg <= count_reg + CW'(1);
      else if (pop && !push)
         count_reg <= count_reg - CW'(1);
   end

endmodule: hp_buf2

// ### test/hp_host_port_monitor.sv
// Purpose: port assertions of the host port
// Assumes: control written with all byte lanes
// Notes: control shadow follows avalon writes
`timescale 1ns/100ps
`include "hp_params.svh"
module hp_host_port_monitor
(
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic        avs_waitrequest,
   input wire logic [1:0]  host_chip_selects,
   input wire logic        host_direction,
   input wire logic        host_read_strobe,
   input wire logic        host_write_strobe,
   input wire logic        host_shared_strobe,
   input wire logic        host_dma_acknowledge,
   input wire logic        host_data_oe,
   input wire logic        host_request_combined,
   input wire logic        host_receive_request,
   input wire logic        host_transmit_request
);
   logic [9:0] ctrl_reg;
   logic       cs_on, rd_on, dma_on, req_on;

   // shadow of the control register
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         ctrl_reg <= `HP_CTRL_RESET;
      else if (avs_write && !avs_waitrequest && avs_address == `HP_AV_CTRL)
         ctrl_reg <= avs_writedata[9:0];
   end

   // active flags; polarity bit zero is active low
   assign cs_on  = |(~(host_chip_selects ^ {2{ctrl_reg[0]}}));
   assign rd_on  = cs_on && (ctrl_reg[4] ? host_read_strobe == ctrl_reg[1]
                   : host_shared_strobe == ctrl_reg[1] && host_direction);
   assign dma_on = ctrl_reg[8] && (ctrl_reg[7] ? (host_read_strobe == ctrl_reg[1]
                   || host_write_strobe == ctrl_reg[1]) : host_dma_acknowledge == ctrl_reg[2]);
   assign req_on = ctrl_reg[5] ? (host_receive_request == ctrl_reg[3]
                   || host_transmit_request == ctrl_reg[3]) : host_request_combined == ctrl_reg[3];

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence rd_start_s;
      !host_data_oe && $rose(rd_on);
   endsequence
   sequence rd_idle_s;
      (!rd_on && !dma_on) [*5];
   endsequence

   rd_sync_a: assert property (rd_start_s |=> !host_data_oe)
      else $error("oe too early");
   rd_valid_a: assert property (rd_start_s |-> ##[2:4] host_data_oe)
      else $error("oe too late");
   oe_hold_a: assert property (host_data_oe && rd_on |=> host_data_oe)
      else $error("oe dropped");
   oe_release_a: assert property (rd_idle_s |-> !host_data_oe)
      else $error("oe stuck");
   dma_drop_a: assert property ($rose(dma_on) |-> ##[1:5] !req_on)
      else $error("dma req kept");
   dma_hold_a: assert property ($fell(dma_on) |-> (!req_on) [*6])
      else $error("dma req early");
   rd_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("read wait wrong");
   wr_wait_a: assert property ($rose(avs_write) |-> avs_waitrequest)
      else $error("no write wait");
endmodule: hp_host_port_monitor

bind hp_host_port hp_host_port_monitor mon_u (.clk, .arst_n, .avs_address, .avs_read,
   .avs_write, .avs_writedata, .avs_waitrequest, .host_chip_selects, .host_direction,
   .host_read_strobe, .host_write_strobe, .host_shared_strobe, .host_dma_acknowledge,
   .host_data_oe, .host_request_combined, .host_receive_request, .host_transmit_request);

// ### test/hp_host_model.sv
// Purpose: external host driving the host pins
// Assumes: host pins active low
// Notes: released data lines invert, so stale words never look valid
`timescale 1ns/100ps
module hp_host_model
(
   input  wire logic        clk,
   input  wire logic [15:0] host_data_out,
   output      logic [1:0]  cs_n,
   output      logic [3:0]  addr,
   output      logic        dir,
   output      logic        rd_n,
   output      logic        wr_n,
   output      logic        ds_n,
   output      logic        ack_n,
   output      logic [15:0] din
);
   // idle pins from time zero
   initial
   begin
      cs_n = 2'h3;
      addr = 4'h0;
      dir = 1'b0;
      rd_n = 1'b1;
      wr_n = 1'b1;
      ds_n = 1'b1;
      ack_n = 1'b1;
      din = 16'h0;
   end

   // one access, gap first so calls may follow back to back
   task automatic xfer(input bit rd, input bit dual, input bit dma, input logic [3:0] a,
                       input logic [15:0] wd, output logic [15:0] q);
      @(posedge clk);
      cs_n <= 2'h3;
      din <= ~din;
      repeat (3) @(posedge clk);
      cs_n <= 2'h2;
      addr <= a;
      dir <= rd;
      if (!rd)
         din <= wd;
      @(posedge clk);
      if (dma)
         ack_n <= 1'b0;
      else if (!dual)
         ds_n <= 1'b0;
      else if (rd)
         rd_n <= 1'b0;
      else
         wr_n <= 1'b0;
      repeat (8) @(posedge clk);
      q = host_data_out;
      ack_n <= 1'b1;
      ds_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
   endtask: xfer
endmodule: hp_host_model

// ### test/test_host_port_handshake.sv
// Purpose: self-checking bench of the host port
// Assumes: wide mode
// Notes: expected words are slices of one word
`timescale 1ns/100ps
module test_host_port_handshake;
   localparam logic [63:0] W = 64'h4444_3333_2222_1111;
   logic        clk, arst_n, avs_read, avs_write, avs_waitrequest, dir, rd_n, wr_n, ds_n;
   logic        ack_n, oe, rq_c, rq_r, rq_t;
   logic [7:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0]  avs_byteenable, addr;
   logic [1:0]  cs_n;
   logic [15:0] din, dout;
   int          errors, num_checks;

   hp_host_port dut_u (.clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .host_chip_selects(cs_n),
      .host_address_lines(addr), .host_direction(dir), .host_read_strobe(rd_n),
      .host_write_strobe(wr_n), .host_shared_strobe(ds_n), .host_dma_acknowledge(ack_n),
      .host_data_in(din), .host_data_out(dout), .host_data_oe(oe),
      .host_request_combined(rq_c), .host_receive_request(rq_r),
      .host_transmit_request(rq_t));
   hp_host_model host_u (.clk, .host_data_out(dout), .cs_n, .addr, .dir, .rd_n, .wr_n,
      .ds_n, .ack_n, .din);

   // 100 MHz core clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask: summarize

   task automatic chk_w(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         errors++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask: chk_w

   task automatic chk_b(input string n, input logic e, input logic g);
      chk_w(n, {31'h0, e}, {31'h0, g});
   endtask: chk_b

   // one avalon access, held until waitrequest is sampled low
   task automatic av(input bit wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do
         @(posedge clk);
      while (avs_waitrequest);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask: av

   // reset values, unmapped read, request polarity flip
   task automatic t_reset();
      logic [31:0] q;
      av(0, 8'h00, 32'h0, q);
      chk_w("ctrl", 32'h210, q);
      av(0, 8'h20, 32'h0, q);
      chk_w("unmapped", 32'h0, q);
      chk_b("req_comb", 1'b0, rq_c);
      av(1, 8'h00, 32'h218, q);
      repeat (2) @(posedge clk);
      #1 chk_b("req_comb", 1'b1, rq_c);
   endtask: t_reset

   // host drains one word per byte order, dual then single strobe
   task automatic t_rx(input bit big);
      logic [31:0] q;
      logic [15:0] h;
      int k;
      av(1, 8'h00, {22'h0, 3'h4, big, 1'b1, !big, 4'h0}, q);
      av(1, 8'h08, W[31:0], q);
      av(1, 8'h0C, W[63:32], q);
      repeat (2) @(posedge clk);
      #1 chk_b("rx_req", 1'b0, rq_r);
      for (int a = 4; a < 8; a++)
      begin
         host_u.xfer(1, !big, 0, a[3:0], 16'h0, h);
         k = big ? a - 4 : 7 - a;
         chk_w("rd_word", {16'h0, W[16*k +: 16]}, {16'h0, h});
      end
      repeat (4) @(posedge clk);
      #1 chk_b("rx_req", 1'b1, rq_r);
   endtask: t_rx

   // fill inbound with dual then single strobes, then drain
   task automatic t_tx();
      logic [31:0] q;
      logic [15:0] h;
      for (int m = 0; m < 2; m++)
      begin
         av(1, 8'h00, m ? 32'h220 : 32'h230, q);
         for (int a = 4; a < 8; a++)
            host_u.xfer(0, !m, 0, a[3:0], W[16*(7-a) +: 16] ^ {16{m[0]}}, h);
      end
      repeat (4) @(posedge clk);
      #1 chk_b("tx_req", 1'b1, rq_t);
      av(0, 8'h10, 32'h0, q);
      chk_w("rx_lo", W[31:0], q);
      av(0, 8'h14, 32'h0, q);
      chk_w("rx_hi", W[63:32], q);
      repeat (4) @(posedge clk);
      #1 chk_b("tx_req", 1'b0, rq_t);
      av(0, 8'h10, 32'h0, q);
      chk_w("rx_lo", ~W[31:0], q);
      av(0, 8'h14, 32'h0, q);
      chk_w("rx_hi", ~W[63:32], q);
   endtask: t_tx

   // dma reads qualified by acknowledge, then by the strobes
   task automatic t_dma();
      logic [31:0] q;
      logic [15:0] h;
      av(1, 8'h00, 32'h310, q);
      av(1, 8'h08, W[31:0], q);
      av(1, 8'h0C, W[63:32], q);
      for (int s = 0; s < 2; s++)
      begin
         av(1, 8'h00, s ? 32'h390 : 32'h310, q);
         host_u.xfer(1, 1, !s, 4'h4, 16'h0, h);
         chk_w("dma_word", {16'h0, W[16*(3-s) +: 16]}, {16'h0, h});
      end
   endtask: t_dma

   // cuts a hang short
   initial
   begin
      #400000;
      errors++;
      summarize();
   end

   // reset, then the scenarios in turn
   initial
   begin
      arst_n = 1'b0;
      avs_address = 8'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      t_reset();
      t_rx(0);
      t_rx(1);
      t_tx();
      t_dma();
      summarize();
   end
endmodule: test_host_port_handshake
